// ### hw/cgo_regs.sv
`timescale 1ns/10ps
`default_nettype none

//
// Operation
// - Address 00000 holds the 10-bit red gain code, reset to zero, zero is least gain.
// - Address 00001 holds the 10-bit green gain code, reset to zero, zero is least gain.
// - Address 00010 holds the 10-bit blue gain code, reset to zero, zero is least gain.
// - Address 00011 holds the red coarse offset code ahead of gain, -80 mV to +160 mV.
// - Address 00100 holds the green coarse offset code with the red coarse mapping.
// - Address 00101 holds the blue coarse offset code with the red coarse mapping.
// - Every coarse offset resets to 0101010101, which is zero millivolts.
// - Address 00110 holds the red fine offset code after gain, -128 mV to +128 mV.
// - Address 00111 holds the green fine offset code with the red fine mapping.
// - Address 01000 holds the blue fine offset code with the red fine mapping.
// - Every fine offset resets to 1000000000, which is zero millivolts.
// - Address 01001 holds a red coarse offset used for even pixels in alternate mode.
// - A read uses only the first eighteen rising serial clock edges of a frame.
// - Writing the control reset bit returns the whole ten-register bank to defaults; the control address stores no bits.
module cgo_regs
    import cgo_pkg::*;
(
    // Clock and reset
    input  wire logic                  I_SYS_CLK,
    input  wire logic                  I_SYS_RST,
    // Serial control port
    input  wire logic                  I_SCLK,
    input  wire logic                  I_LOAD,
    input  wire logic                  I_SDIO,
    output logic                       O_SDIO,
    output logic                       O_SDIO_OE,
    // Pixel context
    input  wire logic                  I_ALTERNATE_PIXEL_OFFSET_MODE,
    input  wire logic                  I_EVEN_PIXEL,
    // Setting codes
    output logic [CGO_DATA_W-1:0]      O_RED_GAIN_CODE,
    output logic [CGO_DATA_W-1:0]      O_GREEN_GAIN_CODE,
    output logic [CGO_DATA_W-1:0]      O_BLUE_GAIN_CODE,
    output logic [CGO_DATA_W-1:0]      O_RED_COARSE_OFFSET_CODE,
    output logic [CGO_DATA_W-1:0]      O_GREEN_COARSE_OFFSET_CODE,
    output logic [CGO_DATA_W-1:0]      O_BLUE_COARSE_OFFSET_CODE,
    output logic [CGO_DATA_W-1:0]      O_RED_FINE_OFFSET_CODE,
    output logic [CGO_DATA_W-1:0]      O_GREEN_FINE_OFFSET_CODE,
    output logic [CGO_DATA_W-1:0]      O_BLUE_FINE_OFFSET_CODE,
    output logic [CGO_DATA_W-1:0]      O_EVEN_PIXEL_RED_COARSE_CODE,
    output logic [CGO_DATA_W-1:0]      O_RED_COARSE_ACTIVE_CODE
);

    // ------------------------------------------------------------
    // Serial clock edge detect
    // ------------------------------------------------------------
    logic                          sclk_q;
    logic                          sclk_d;
    logic                          rise;

    assign sclk_d = I_SCLK;
    assign rise   = I_SCLK & ~sclk_q & I_LOAD;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk_d;
        end
    end

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    cgo_state_t                    state_q;
    cgo_state_t                    state_d;
    logic [CGO_CNT_W-1:0]          cnt_q;
    logic [CGO_CNT_W-1:0]          cnt_d;
    logic [CGO_DATA_W-1:0]         sh_q;
    logic [CGO_DATA_W-1:0]         sh_d;
    logic                          rw_q;
    logic                          rw_d;
    logic [CGO_ADDR_W-1:0]         addr_q;
    logic [CGO_ADDR_W-1:0]         addr_d;
    logic [CGO_DATA_W-1:0]         rd_q;
    logic [CGO_DATA_W-1:0]         rd_d;
    logic                          sdo_q;
    logic                          sdo_d;
    logic                          oe_q;
    logic                          oe_d;
    logic                          wr_stb;
    logic [CGO_DATA_W-1:0]         wr_data;
    logic [CGO_DATA_W-1:0]         rd_mux;
    logic [CGO_NUM_REGS-1:0][CGO_DATA_W-1:0] bank;

    always_comb begin
        rd_mux = '0;
        if (addr_q < CGO_ADDR_W'(CGO_NUM_REGS)) begin
            rd_mux = bank[addr_q];
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        rw_d    = rw_q;
        addr_d  = addr_q;
        rd_d    = rd_q;
        sdo_d   = sdo_q;
        oe_d    = oe_q;
        wr_stb  = 1'b0;
        wr_data = {sh_q[CGO_DATA_W-2:0], I_SDIO};
        if (!I_LOAD) begin
            state_d = CGO_ST_IDLE;
            cnt_d   = '0;
            oe_d    = 1'b0;
        end else if (rise) begin
            case (state_q)
                CGO_ST_IDLE, CGO_ST_HEAD: begin
                    state_d = CGO_ST_HEAD;
                    cnt_d   = cnt_q + 5'h01;
                    sh_d    = {sh_q[CGO_DATA_W-2:0], I_SDIO};
                    if (cnt_d == CGO_HEAD_EDGES) begin
                        rw_d   = sh_q[CGO_ADDR_W-1];
                        addr_d = {sh_q[CGO_ADDR_W-2:0], I_SDIO};
                    end
                    // Turnaround bits: pin free, first data bit goes out
                    if (cnt_d == CGO_TURN_EDGE) begin
                        state_d = CGO_ST_DATA;
                        if (rw_q) begin
                            rd_d  = {rd_mux[CGO_DATA_W-2:0], 1'b0};
                            sdo_d = rd_mux[CGO_DATA_W-1];
                            oe_d  = 1'b1;
                        end
                    end
                end
                CGO_ST_DATA: begin
                    cnt_d = cnt_q + 5'h01;
                    sh_d  = {sh_q[CGO_DATA_W-2:0], I_SDIO};
                    if (cnt_d == CGO_FRAME_BITS) begin
                        // Later edges are ignored until the frame ends
                        state_d = CGO_ST_DONE;
                        wr_stb  = ~rw_q;
                    end else if (rw_q) begin
                        sdo_d = rd_q[CGO_DATA_W-1];
                        rd_d  = {rd_q[CGO_DATA_W-2:0], 1'b0};
                    end
                end
                CGO_ST_DONE: begin
                    state_d = CGO_ST_DONE;
                end
                default: begin
                    state_d = CGO_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            state_q <= CGO_ST_IDLE;
            cnt_q   <= '0;
            sh_q    <= '0;
            rw_q    <= 1'b0;
            addr_q  <= '0;
            rd_q    <= '0;
            sdo_q   <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            rw_q    <= rw_d;
            addr_q  <= addr_d;
            rd_q    <= rd_d;
            sdo_q   <= sdo_d;
            oe_q    <= oe_d;
        end
    end

    assign O_SDIO    = sdo_q;
    assign O_SDIO_OE = oe_q;

    // ------------------------------------------------------------
    // Bank reset from the control register
    // ------------------------------------------------------------
    // Bit pulses for one cycle; the control address is outside the bank, so it reads back as zero
    logic clr_q;
    logic clr_d;

    always_comb begin
        clr_d = wr_stb && (addr_q == CGO_ADDR_CONTROL) && wr_data[CGO_RESET_BIT];
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            clr_q <= 1'b0;
        end else begin
            clr_q <= clr_d;
        end
    end

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < CGO_NUM_REGS; gi++) begin : g_cell
            cgo_reg_cell #(
                .W   (CGO_DATA_W),
                .RST (CGO_RST_TABLE[gi])
            ) u_cell (
                .i_clk   (I_SYS_CLK),
                .i_rst   (I_SYS_RST),
                .i_clr   (clr_q),
                .i_we    (wr_stb && (addr_q == CGO_ADDR_W'(gi))),
                .i_wdata (wr_data),
                .o_q     (bank[gi])
            );
        end
    endgenerate

    assign O_RED_GAIN_CODE              = bank[CGO_ADDR_RED_GAIN];
    assign O_GREEN_GAIN_CODE            = bank[CGO_ADDR_GREEN_GAIN];
    assign O_BLUE_GAIN_CODE             = bank[CGO_ADDR_BLUE_GAIN];
    assign O_RED_COARSE_OFFSET_CODE     = bank[CGO_ADDR_RED_COARSE];
    assign O_GREEN_COARSE_OFFSET_CODE   = bank[CGO_ADDR_GREEN_COARSE];
    assign O_BLUE_COARSE_OFFSET_CODE    = bank[CGO_ADDR_BLUE_COARSE];
    assign O_RED_FINE_OFFSET_CODE       = bank[CGO_ADDR_RED_FINE];
    assign O_GREEN_FINE_OFFSET_CODE     = bank[CGO_ADDR_GREEN_FINE];
    assign O_BLUE_FINE_OFFSET_CODE      = bank[CGO_ADDR_BLUE_FINE];
    assign O_EVEN_PIXEL_RED_COARSE_CODE = bank[CGO_ADDR_EVEN_RED_COARSE];

    // ------------------------------------------------------------
    // Red coarse code in use for the current pixel
    // ------------------------------------------------------------
    logic [CGO_DATA_W-1:0] act_q;
    logic [CGO_DATA_W-1:0] act_d;

    always_comb begin
        act_d = bank[CGO_ADDR_RED_COARSE];
        if (I_ALTERNATE_PIXEL_OFFSET_MODE && I_EVEN_PIXEL) begin
            act_d = bank[CGO_ADDR_EVEN_RED_COARSE];
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            act_q <= CGO_RST_COARSE;
        end else begin
            act_q <= act_d;
        end
    end

    assign O_RED_COARSE_ACTIVE_CODE = act_q;

endmodule : cgo_regs

`default_nettype wire

// ### hw/cgo_pkg.sv
package cgo_pkg;

    // ------------------------------------------------------------
    // Widths and frame layout
    // ------------------------------------------------------------
    localparam int          CGO_DATA_W     = 10;
    localparam int          CGO_ADDR_W     = 5;
    localparam int          CGO_NUM_REGS   = 10;
    localparam int          CGO_CNT_W      = 5;
    localparam logic [4:0]  CGO_HEAD_EDGES = 5'h06;
    localparam logic [4:0]  CGO_TURN_EDGE  = 5'h08;
    localparam logic [4:0]  CGO_FRAME_BITS = 5'h12;
    localparam int          CGO_RESET_BIT  = 0;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [4:0]  CGO_ADDR_RED_GAIN        = 5'h00;
    localparam logic [4:0]  CGO_ADDR_GREEN_GAIN      = 5'h01;
    localparam logic [4:0]  CGO_ADDR_BLUE_GAIN       = 5'h02;
    localparam logic [4:0]  CGO_ADDR_RED_COARSE      = 5'h03;
    localparam logic [4:0]  CGO_ADDR_GREEN_COARSE    = 5'h04;
    localparam logic [4:0]  CGO_ADDR_BLUE_COARSE     = 5'h05;
    localparam logic [4:0]  CGO_ADDR_RED_FINE        = 5'h06;
    localparam logic [4:0]  CGO_ADDR_GREEN_FINE      = 5'h07;
    localparam logic [4:0]  CGO_ADDR_BLUE_FINE       = 5'h08;
    localparam logic [4:0]  CGO_ADDR_EVEN_RED_COARSE = 5'h09;
    localparam logic [4:0]  CGO_ADDR_CONTROL         = 5'h0f;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [9:0]  CGO_RST_GAIN   = 10'h000;
    localparam logic [9:0]  CGO_RST_COARSE = 10'h155;
    localparam logic [9:0]  CGO_RST_FINE   = 10'h200;

    // Indexed by register address
    localparam logic [CGO_NUM_REGS-1:0][CGO_DATA_W-1:0] CGO_RST_TABLE = {
        CGO_RST_COARSE, CGO_RST_FINE, CGO_RST_FINE, CGO_RST_FINE,
        CGO_RST_COARSE, CGO_RST_COARSE, CGO_RST_COARSE,
        CGO_RST_GAIN, CGO_RST_GAIN, CGO_RST_GAIN
    };

    typedef enum logic [1:0] {
        CGO_ST_IDLE = 2'b00,
        CGO_ST_HEAD = 2'b01,
        CGO_ST_DATA = 2'b10,
        CGO_ST_DONE = 2'b11
    } cgo_state_t;

endpackage : cgo_pkg

// ### hw/cgo_reg_cell.sv
`timescale 1ns/10ps
`default_nettype none

module cgo_reg_cell #(
    parameter int               W   = 10,
    parameter logic [W-1:0]     RST = '0
) (
    // Clock and reset
    input  wire logic           i_clk,
    input  wire logic           i_rst,
    // Control
    input  wire logic           i_clr,
    input  wire logic           i_we,
    input  wire logic [W-1:0]   i_wdata,
    // Stored value
    output logic      [W-1:0]   o_q
);

    logic [W-1:0] val_d;

    always_comb begin
        val_d = o_q;
        if (i_clr) begin
            val_d = RST;
        end else if (i_we) begin
            val_d = i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_q <= RST;
        end else begin
            o_q <= val_d;
        end
    end

endmodule : cgo_reg_cell

`default_nettype wire

// ### verification/cgo_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module cgo_regs_sva
    import cgo_pkg::*;
(
    // Clock, reset, serial port and pixel context
    input wire logic I_SYS_CLK, I_SYS_RST, I_SCLK, I_LOAD, O_SDIO, O_SDIO_OE,
    input wire logic I_ALTERNATE_PIXEL_OFFSET_MODE, I_EVEN_PIXEL,
    // Setting codes
    input wire logic [CGO_DATA_W-1:0] O_RED_GAIN_CODE, O_GREEN_GAIN_CODE, O_BLUE_GAIN_CODE,
    input wire logic [CGO_DATA_W-1:0] O_RED_COARSE_OFFSET_CODE, O_GREEN_COARSE_OFFSET_CODE,
    input wire logic [CGO_DATA_W-1:0] O_BLUE_COARSE_OFFSET_CODE, O_RED_FINE_OFFSET_CODE,
    input wire logic [CGO_DATA_W-1:0] O_GREEN_FINE_OFFSET_CODE, O_BLUE_FINE_OFFSET_CODE,
    input wire logic [CGO_DATA_W-1:0] O_EVEN_PIXEL_RED_COARSE_CODE, O_RED_COARSE_ACTIVE_CODE
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    // ----------------------------------------
    // Bank view
    // ----------------------------------------
    wire logic [99:0] bank = {O_RED_GAIN_CODE, O_GREEN_GAIN_CODE, O_BLUE_GAIN_CODE,
        O_RED_COARSE_OFFSET_CODE, O_GREEN_COARSE_OFFSET_CODE, O_BLUE_COARSE_OFFSET_CODE,
        O_RED_FINE_OFFSET_CODE, O_GREEN_FINE_OFFSET_CODE, O_BLUE_FINE_OFFSET_CODE,
        O_EVEN_PIXEL_RED_COARSE_CODE};
    wire logic [9:0] sel = (I_ALTERNATE_PIXEL_OFFSET_MODE && I_EVEN_PIXEL)
        ? O_EVEN_PIXEL_RED_COARSE_CODE : O_RED_COARSE_OFFSET_CODE;
    AST_GAIN_RST: assert property ($fell(I_SYS_RST) |->
        bank[99:70] == '0) else $error("gain code off default");
    AST_COARSE_RST: assert property ($fell(I_SYS_RST) |->
        bank[69:40] == {3{10'h155}} && bank[9:0] == 10'h155) else $error("coarse off default");
    AST_FINE_RST: assert property ($fell(I_SYS_RST) |->
        bank[39:10] == {3{10'h200}}) else $error("fine code off default");
    AST_ACTIVE_SEL: assert property (1'b1 |=> O_RED_COARSE_ACTIVE_CODE == $past(sel))
        else $error("active coarse code wrong");
    AST_CODE_FRAME: assert property ($changed(bank) |->
        $past(I_LOAD) || $past(I_LOAD, 2) || $past(I_LOAD, 3)) else $error("code changed idle");
    AST_SDIO_ON_RISE: assert property (O_SDIO_OE && $changed(O_SDIO) |->
        $past(I_SCLK) && !$past(I_SCLK, 2)) else $error("read bit moved off a rise");
    AST_OE_RISE: assert property ($rose(O_SDIO_OE) |->
        $past(I_LOAD) && $past(I_SCLK) && !$past(I_SCLK, 2)) else $error("drive began off rise");
    AST_OE_OFF: assert property (!I_LOAD |=> !O_SDIO_OE)
        else $error("data line driven outside frame");
    COV_READ: cover property ($rose(O_SDIO_OE));
    COV_WRITE: cover property ($changed(bank));
    COV_EVEN: cover property (I_ALTERNATE_PIXEL_OFFSET_MODE && I_EVEN_PIXEL ##1 1'b1);
endmodule : cgo_regs_sva
bind cgo_regs cgo_regs_sva u_cgo_regs_sva (.*);
`default_nettype wire

// ### verification/cgo_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cgo_host_model (
    // Clock and wire level
    input  wire logic i_clk,
    input  wire logic i_sdio,
    // Serial port drive
    output var logic  o_sclk,
    output var logic  o_load,
    output var logic  o_sdio,
    output var logic  o_sdio_oe
);
    // ----------------------------------------
    // Frames
    // ----------------------------------------
    initial begin
        o_sclk = 1'b0;
        o_load = 1'b0;
        o_sdio = 1'b0;
        o_sdio_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    // Serial clock rests low between frames; 3 cycles each phase
    task automatic frame(input logic rw, input logic [4:0] a, input logic [9:0] d,
                         input int n, output logic [9:0] q);
        logic [17:0] bits;
        bits = {rw, a, 2'b00, d};
        q = '0;
        o_load = 1'b1;
        for (int k = 0; k < n; k++) begin
            o_sdio_oe = !(rw && k >= 6);
            // Past bit 18 send inverted junk
            o_sdio = bits[17-(k%18)] ^ (k >= 18);
            tick(3);
            if (rw && k >= 8 && k < 18) q[17-k] = i_sdio;
            o_sclk = 1'b1;
            tick(3);
            o_sclk = 1'b0;
        end
        o_sdio_oe = 1'b0;
        tick(3);
        o_load = 1'b0;
        tick(3);
    endtask : frame
endmodule : cgo_host_model
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import cgo_pkg::*;
    // ----------------------------------------
    // Pins, instances and checks
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic alt_mode = 1'b0;
    logic even_pix = 1'b0;
    wire logic sclk, load, host_sdio, host_oe, dev_sdio, dev_oe;
    wire logic [CGO_DATA_W-1:0] codes [11];
    int n_errors = 0;
    int check_count = 0;
    logic [CGO_DATA_W-1:0] q;
    always #2.5 sys_clk = ~sys_clk;
    // Pull-down on the pin: a released line reads low
    wire logic sdio_w = dev_oe ? dev_sdio : (host_oe & host_sdio);
    cgo_host_model u_cgo_host_model (.i_clk(sys_clk), .i_sdio(sdio_w), .o_sclk(sclk),
        .o_load(load), .o_sdio(host_sdio), .o_sdio_oe(host_oe));
    cgo_regs u_cgo_regs (.I_SYS_CLK(sys_clk), .I_SYS_RST(sys_rst), .I_SCLK(sclk),
        .I_LOAD(load), .I_SDIO(sdio_w), .O_SDIO(dev_sdio), .O_SDIO_OE(dev_oe),
        .I_ALTERNATE_PIXEL_OFFSET_MODE(alt_mode), .I_EVEN_PIXEL(even_pix),
        .O_RED_GAIN_CODE(codes[0]), .O_GREEN_GAIN_CODE(codes[1]), .O_BLUE_GAIN_CODE(codes[2]),
        .O_RED_COARSE_OFFSET_CODE(codes[3]), .O_GREEN_COARSE_OFFSET_CODE(codes[4]),
        .O_BLUE_COARSE_OFFSET_CODE(codes[5]), .O_RED_FINE_OFFSET_CODE(codes[6]),
        .O_GREEN_FINE_OFFSET_CODE(codes[7]), .O_BLUE_FINE_OFFSET_CODE(codes[8]),
        .O_EVEN_PIXEL_RED_COARSE_CODE(codes[9]), .O_RED_COARSE_ACTIVE_CODE(codes[10]));
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    function automatic logic [9:0] dflt(input int a);
        return (a < 3) ? 10'h000 : (a < 6 || a == 9) ? 10'h155 : 10'h200;
    endfunction : dflt
    function automatic logic [9:0] wval(input int a);
        return 10'h3ff >> a;
    endfunction : wval
    task automatic wr(input logic [4:0] a, input logic [9:0] d, input int n);
        logic [9:0] unused;
        u_cgo_host_model.frame(1'b0, a, d, n, unused);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        u_cgo_host_model.frame(1'b1, a, 10'h000, 18, q);
    endtask : rd
    task automatic bank_is(input logic use_dflt);
        for (int a = 0; a < 10; a++) begin
            rd(a[4:0]);
            check(q, use_dflt ? dflt(a) : wval(a));
            check(codes[a], use_dflt ? dflt(a) : wval(a));
        end
    endtask : bank_is
    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        bank_is(1'b1);
        for (int a = 0; a < 10; a++) wr(a[4:0], wval(a), 18);
        bank_is(1'b0);
        // Unmapped places keep nothing
        wr(5'h0a, 10'h3ff, 18);
        check(codes[2], wval(2));
        rd(5'h0a);
        check(q, 10'h000);
        rd(5'h1f);
        check(q, 10'h000);
        // Cut-short frame stores nothing, surplus rises are ignored
        wr(5'h00, 10'h0aa, 10);
        check(codes[0], wval(0));
        wr(5'h01, 10'h0aa, 22);
        rd(5'h01);
        check(q, 10'h0aa);
        for (int m = 0; m < 4; m++) begin
            alt_mode = m[1];
            even_pix = m[0];
            repeat (2) @(posedge sys_clk);
            #1;
            check(codes[10], (m == 3) ? wval(9) : wval(3));
        end
        wr(CGO_ADDR_CONTROL, 10'h001, 18);
        bank_is(1'b1);
        rd(CGO_ADDR_CONTROL);
        check(q, 10'h000);
        wr(5'h02, 10'h3ff, 18);
        check(codes[2], 10'h3ff);
        sys_rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        bank_is(1'b1);
        finish_test();
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
